// File: pgm_defs.svh
/*
 Constants of the power-good and overload monitor: register offsets,
 field positions, reset values and timing counts.
 Assumes a 200 MHz system clock.
*/
`ifndef PGM_DEFS_SVH
`define PGM_DEFS_SVH

`define PGM_CLK_MHZ 200
`define PGM_GATE_US 800
`define PGM_GATE_CYC (`PGM_GATE_US * `PGM_CLK_MHZ)
`define PGM_BUCK_LIM_US 20
`define PGM_BUCK_LIM_CYC (`PGM_BUCK_LIM_US * `PGM_CLK_MHZ)
`define PGM_BOOST_LIM_US 64
`define PGM_BOOST_LIM_CYC (`PGM_BOOST_LIM_US * `PGM_CLK_MHZ)
`define PGM_SC_DLY_US 1000
`define PGM_SC_DLY_CYC (`PGM_SC_DLY_US * `PGM_CLK_MHZ)

`define PGM_ADDR_W 4
`define PGM_REG_CTRL 4'h0
`define PGM_REG_FAULT 4'h1
`define PGM_REG_INT 4'h2
`define PGM_REG_STAT 4'h3
`define PGM_REG_EN 4'h4

`define PGM_CTRL_RST 8'h00
`define PGM_EN_RST 8'h00

`define PGM_CTRL_MODE0 0
`define PGM_CTRL_MODE1 1
`define PGM_CTRL_HOLD0 2
`define PGM_CTRL_HOLD1 3

`define PGM_INT_BUCKSC0 0
`define PGM_INT_BUCKSC1 1
`define PGM_INT_BOOSTSC 2
`define PGM_INT_BUCKLIM0 3
`define PGM_INT_BUCKLIM1 4
`define PGM_INT_BOOSTLIM 5
`define PGM_INT_OVERTEMP 6
`define PGM_INT_OVERVOLT 7
`define PGM_INT_SUPLOSS 8

`endif

// File: pgm_host_model.sv
/* Host supervisor: runs the processor only while both power-good outputs
 are good and no interrupt is pending. Assumes clk_sys is shared. */
`timescale 1ns/1ps
`default_nettype none
module pgm_host_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [1:0] power_good_out,
    input wire logic irq_out_n,
    output logic hostRun
);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            hostRun <= 1'b0;
        else
            hostRun <= (power_good_out == 2'h3) && irq_out_n;
    end
endmodule
`default_nettype wire

// File: pgm_monitor.sv
/*
 Power-good and overload monitor: gated and continuous power-good outputs,
 buck and boost current-limit warnings and short-circuit shutdown flags.
 Assumes analog monitor levels arrive asynchronous and are synchronised here,
 and that the host bus is synchronous to clk_sys.
*/
// Function
// - Power-good low until device reaches standby.
// - Rails with monitor select 0 never contribute faults.
// - Host-disabled monitored rail contributes no fault.
// - Start-up delay: gated good, continuous fault.
// - Start-up: gated fault only after 800 us, continuous until valid.
// - Good only after output stayed in window past debounce.
// - Debounced excursions beyond thresholds are faults.
// - Voltage ramp: gated fault after 800 us, continuous fault throughout.
// - No fault during shutdown delay, ramp down, or discharge.
// - Pending short-circuit flag of monitored converter is a fault.
// - Pending overtemperature flag is a fault.
// - Pending input overvoltage flag is a fault.
// - Analog supply undervoltage drives power-good low.
// - Power-good inactive on any fault, active only with none.
// - Power-good from live faults plus device flags; latched bits only in gated or hold mode.
// - Buck peak limit 20 us sets flag, interrupt; live state bit.
// - Buck limit interrupt suppressed in start-up and ramps.
// - Buck below 350 mV disables buck, sets short flag; write 1 clears.
// - Boost peak limit 64 us sets flag, interrupt; live state bit.
// - Boost low 1 ms disables; 2.5 V stops at once; short flag.
// - Negative current limit makes no interrupt and no disable.
// - Rail fault bits latch until written 1; 0 leaves them.
// - Hold option keeps power-good low while fault bits pending.
`timescale 1ns/1ps
`default_nettype none
`include "pgm_defs.svh"

module pgm_monitor
    import pgm_pkg::*;
#(
    parameter int GATE_CYC = `PGM_GATE_CYC,
    parameter int BUCK_LIM_CYC = `PGM_BUCK_LIM_CYC,
    parameter int BOOST_LIM_CYC = `PGM_BOOST_LIM_CYC,
    parameter int SC_DLY_CYC = `PGM_SC_DLY_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire pgm_rail_s [NRAIL-1:0] railIn,
    input wire pgm_dev_s devIn,
    input wire logic [`PGM_ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    output logic [1:0] power_good_out,
    output logic irq_out_n,
    output logic [NRAIL-1:0] railRunOut,
    output logic [NRAIL-1:0] railSwitchOut
);

    // Two-flop synchronisers; stage one is read only by stage two
    pgm_rail_s [NRAIL-1:0] railS1Q, railQ;
    pgm_dev_s devS1Q, devQ;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            railS1Q <= '0;
            railQ <= '0;
            devS1Q <= '0;
            devQ <= '0;
        end else if (clkEn) begin
            railS1Q <= railIn;
            railQ <= railS1Q;
            devS1Q <= devIn;
            devQ <= devS1Q;
        end
    end

    logic [7:0] ctrlQ;  // mode and hold bits
    logic [7:0] enQ;    // [2:0] on bits; [7:3] stored and read back only, monitor select is in monSelQ
    logic [5:0] monSelQ;  // [2:0] PG0 select, [5:3] PG1 select
    logic [NRAIL-1:0] rfaultQ [2];
    logic [8:0] intQ;
    logic [1:0] pgQ;
    logic irqNQ;  // Kept as the pin level so the output needs no inverter
    logic [15:0] rdQ;

    wire wrCtrl = clkEn && regWr && regAddr == `PGM_REG_CTRL;
    wire wrFault = clkEn && regWr && regAddr == `PGM_REG_FAULT;
    wire wrInt = clkEn && regWr && regAddr == `PGM_REG_INT;
    wire wrEn = clkEn && regWr && regAddr == `PGM_REG_EN;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrlQ <= `PGM_CTRL_RST;
            monSelQ <= '0;
        end else if (wrCtrl) begin
            ctrlQ <= regWdata[7:0];
            monSelQ <= regWdata[13:8];
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            enQ <= `PGM_EN_RST;
        end else if (wrEn) begin
            enQ <= regWdata[7:0];
        end
    end

    // A converter is on when its bit is set without pin control, or under pin control with pin high
    function automatic logic railOn(input logic onBit, input pgm_rail_s r);
        return r.pinCtrl ? r.enPin : onBit;
    endfunction

    // Counts while run holds, stops at full; a dropped run restarts from zero
    function automatic logic [31:0] satInc(input logic [31:0] c, input logic run,
                                           input logic full);
        if (!run) begin
            return 32'h0000_0000;
        end
        return full ? c : c + 32'h0000_0001;
    endfunction

    logic [NRAIL-1:0] onNow, scFlag, runQ, swQ;
    logic [31:0] gateCntQ [NRAIL];
    logic [31:0] limCntQ [NRAIL];
    logic [31:0] scCntQ [NRAIL];
    logic [NRAIL-1:0] gateOver, limHit, scHit, stopNow;
    logic [NRAIL-1:0] rawFault [2];
    logic [NRAIL-1:0] monFault, contFault, gatedFault;
    assign scFlag = {intQ[`PGM_INT_BOOSTSC], intQ[`PGM_INT_BUCKSC1], intQ[`PGM_INT_BUCKSC0]};

    for (genvar i = 0; i < NRAIL; i++) begin : gRail
        // Missing standby, overtemperature and overvoltage flags and pending short keep the converter off
        assign onNow[i] = railOn(enQ[i], railQ[i]) && !scFlag[i] && devQ.standby
                          && !devQ.overTemp && !devQ.overVolt
                          && !intQ[`PGM_INT_OVERTEMP] && !intQ[`PGM_INT_OVERVOLT];
        wire transit = railQ[i].delaying || railQ[i].ramping || railQ[i].vChange;
        assign gateOver[i] = gateCntQ[i] >= GATE_CYC;
        assign limHit[i] = limCntQ[i] >= ((i == 2) ? BOOST_LIM_CYC : BUCK_LIM_CYC);
        assign scHit[i] = scCntQ[i] >= SC_DLY_CYC;
        // Boost at the hard floor stops switching at once
        assign stopNow[i] = (i == 2) && railQ[i].stopLevel;

        // Saturating, so a window once run out stays run out until transit ends or the rail turns off
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                gateCntQ[i] <= '0;
            end else if (clkEn) begin
                gateCntQ[i] <= satInc(gateCntQ[i], onNow[i] && transit, gateOver[i]);
            end
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                limCntQ[i] <= '0;
            end else if (clkEn) begin
                limCntQ[i] <= satInc(limCntQ[i], onNow[i] && railQ[i].peakLimit,
                                     limHit[i]);
            end
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                scCntQ[i] <= '0;
            end else if (clkEn) begin
                scCntQ[i] <= satInc(scCntQ[i], onNow[i] && railQ[i].shortLevel,
                                    scHit[i]);
            end
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                runQ[i] <= 1'b0;
            end else if (clkEn) begin
                runQ[i] <= onNow[i] && !scHit[i];
            end
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                swQ[i] <= 1'b0;
            end else if (clkEn) begin
                swQ[i] <= onNow[i] && !scHit[i] && !stopNow[i];
            end
        end

        // Continuous: any transit or invalid debounced output is a fault
        assign contFault[i] = transit || !railQ[i].outDebounced;
        // Gated: only after the gate window, or an excursion in steady run
        assign gatedFault[i] = transit ? gateOver[i]
                               : !railQ[i].outDebounced;
        // No fault while off, shutting down or discharging
        wire quiet = !onNow[i] || railQ[i].shutdownDly || railQ[i].discharging;
        assign rawFault[0][i] = !quiet && (ctrlQ[`PGM_CTRL_MODE0] ? contFault[i] : gatedFault[i]);
        assign rawFault[1][i] = !quiet && (ctrlQ[`PGM_CTRL_MODE1] ? contFault[i] : gatedFault[i]);
    end

    // Latched fault bits: set wins over a write-one clear
    for (genvar p = 0; p < 2; p++) begin : gFault
        wire [NRAIL-1:0] sel = monSelQ[p*3 +: 3];
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                rfaultQ[p] <= '0;
            end else if (clkEn) begin
                rfaultQ[p] <= (rfaultQ[p] & ~(wrFault ? regWdata[p*3 +: 3] : 3'h0))
                              | (rawFault[p] & sel);
            end
        end
    end

    // Interrupt flags: set wins over write-one clear; level sources re-set
    logic [8:0] intSet;
    always_comb begin
        intSet = '0;
        intSet[`PGM_INT_BUCKSC0] = scHit[0];
        intSet[`PGM_INT_BUCKSC1] = scHit[1];
        intSet[`PGM_INT_BOOSTSC] = scHit[2];
        // Start-up and ramp gate the buck warnings; negative limit has no input
        intSet[`PGM_INT_BUCKLIM0] = limHit[0] && !railQ[0].delaying
                                    && !railQ[0].ramping && !railQ[0].vChange;
        intSet[`PGM_INT_BUCKLIM1] = limHit[1] && !railQ[1].delaying
                                    && !railQ[1].ramping && !railQ[1].vChange;
        intSet[`PGM_INT_BOOSTLIM] = limHit[2];
        intSet[`PGM_INT_OVERTEMP] = devQ.overTemp;
        intSet[`PGM_INT_OVERVOLT] = devQ.overVolt;
        intSet[`PGM_INT_SUPLOSS] = devQ.analogUvlo;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            intQ <= '0;
        end else if (clkEn) begin
            intQ <= (intQ & ~(wrInt ? regWdata[8:0] : 9'h000)) | intSet;
        end
    end

    // Power-good combine
    logic [1:0] pgD;
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            monFault = rawFault[p] & monSelQ[p*3 +: 3];
            pgD[p] = devQ.standby && !devQ.analogUvlo
                     && !(|monFault)
                     && !(|(scFlag & monSelQ[p*3 +: 3]))
                     && !intQ[`PGM_INT_OVERTEMP] && !intQ[`PGM_INT_OVERVOLT]
                     && !intQ[`PGM_INT_SUPLOSS]
                     // Gated mode resumes only once the host clears the latched bits
                     && !((ctrlQ[`PGM_CTRL_HOLD0 + p] || !ctrlQ[`PGM_CTRL_MODE0 + p])
                          && |rfaultQ[p]);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pgQ <= 2'h0;
        end else if (clkEn) begin
            pgQ <= pgD;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irqNQ <= 1'b1;
        end else if (clkEn) begin
            irqNQ <= !(|intQ);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdQ <= '0;
        end else if (clkEn) begin
            rdQ <= '0;
            if (regRd) begin
                unique case (regAddr)
                    `PGM_REG_CTRL: rdQ <= {2'h0, monSelQ, ctrlQ};
                    `PGM_REG_FAULT: rdQ <= {10'h000, rfaultQ[1], rfaultQ[0]};
                    `PGM_REG_INT: rdQ <= {7'h00, intQ};
                    `PGM_REG_STAT: rdQ <= {5'h00, pgQ, swQ, runQ,
                                           railQ[2].peakLimit, railQ[1].peakLimit,
                                           railQ[0].peakLimit};
                    `PGM_REG_EN: rdQ <= {8'h00, enQ};
                    default: rdQ <= '0;
                endcase
            end
        end
    end

    assign regRdata = rdQ;
    assign power_good_out = pgQ;
    assign irq_out_n = irqNQ;
    assign railRunOut = runQ;
    assign railSwitchOut = swQ;
endmodule
`default_nettype wire

// File: pgm_monitor_props.sv
/* Port checker for pgm_monitor.
 Assumes one clock domain and small count parameters from the bench. */
`timescale 1ns/1ps
`default_nettype none
`include "pgm_defs.svh"
module pgm_monitor_props
    import pgm_pkg::*;
#(
    parameter int BUCK_LIM_CYC = `PGM_BUCK_LIM_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire pgm_rail_s [NRAIL-1:0] railIn,
    input wire pgm_dev_s devIn,
    input wire logic [`PGM_ADDR_W-1:0] regAddr,
    input wire logic regRd,
    input wire logic [15:0] regRdata,
    input wire logic [1:0] power_good_out,
    input wire logic irq_out_n,
    input wire logic [NRAIL-1:0] railRunOut,
    input wire logic [NRAIL-1:0] railSwitchOut
);
    int limCnt_q;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Sync and flag stages add some cycles on top of the limit count
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            limCnt_q <= 0;
        else if (railIn[0].peakLimit && !railIn[0].ramping && railRunOut[0])
            limCnt_q <= limCnt_q + 1;
        else
            limCnt_q <= 0;
    end
    chk_standby_low: assert property (!devIn.standby [*6] |=> power_good_out == 2'h0)
        else $error("Power good high before standby");
    chk_uvlo_low: assert property (devIn.analogUvlo [*6] |=> power_good_out == 2'h0)
        else $error("Power good high in undervoltage");
    chk_overtemp_fault: assert property (devIn.overTemp [*6] |=> !irq_out_n && !power_good_out)
        else $error("Overtemperature not reported");
    chk_overvolt_fault: assert property (devIn.overVolt [*6] |=> !irq_out_n && !power_good_out)
        else $error("Overvoltage not reported");
    chk_rdata_idle: assert property (clkEn && !regRd |=> regRdata == 16'h0000)
        else $error("Read data outside read slot");
    chk_unmapped_zero: assert property (regRd && clkEn && regAddr > `PGM_REG_EN |=> regRdata == 16'h0000)
        else $error("Unmapped read not zero");
    chk_buck_limit: assert property (limCnt_q == BUCK_LIM_CYC + 8 |-> !irq_out_n)
        else $error("Buck limit interrupt missing");
    chk_boost_stop: assert property (railIn[2].stopLevel [*5] |=> !railSwitchOut[2])
        else $error("Boost still switching at stop level");
endmodule
bind pgm_monitor pgm_monitor_props #(.BUCK_LIM_CYC(BUCK_LIM_CYC)) u_props (
    .clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .railIn(railIn), .devIn(devIn),
    .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata), .power_good_out(power_good_out),
    .irq_out_n(irq_out_n), .railRunOut(railRunOut), .railSwitchOut(railSwitchOut));
`default_nettype wire

// File: pgm_pkg.sv
/*
 Types of the power-good and overload monitor.
 Assumes pgm_defs.svh for constants.
*/
package pgm_pkg;
    localparam int NRAIL = 3;

    typedef enum logic [1:0] {
        RAIL_OFF, RAIL_DELAY, RAIL_RAMP, RAIL_RUN
    } pgm_rail_e;

    // Per-rail analog monitor sample: index 0,1 bucks, 2 boost
    typedef struct packed {
        logic delaying;
        logic ramping;
        logic vChange;
        logic inWindow;
        logic outDebounced;
        logic peakLimit;
        logic shortLevel;
        logic stopLevel;
        logic shutdownDly;
        logic discharging;
        logic pinCtrl;
        logic enPin;
    } pgm_rail_s;

    typedef struct packed {
        logic overTemp;
        logic overVolt;
        logic analogUvlo;
        logic standby;
    } pgm_dev_s;
endpackage

// File: power_good_and_overload_monitor_test.sv
/* Self-checking bench for pgm_monitor with shortened counts.
 Assumes the strobe register port and one 200 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
`include "pgm_defs.svh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module power_good_and_overload_monitor_test
    import pgm_pkg::*;
;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic clkEn = 1'b1;
    pgm_rail_s [NRAIL-1:0] railIn = '0;
    pgm_dev_s devIn = '0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata;
    logic [1:0] power_good_out;
    logic irq_out_n;
    logic [2:0] railRunOut;
    logic [2:0] railSwitchOut;
    logic hostRun;
    logic [7:0] rnd = 8'h30;
    int miscompares = 0;
    int comparisons = 0;
    int r;
    always #2.5 clk_sys = ~clk_sys;
    pgm_monitor #(.GATE_CYC(20), .BUCK_LIM_CYC(4), .BOOST_LIM_CYC(12), .SC_DLY_CYC(25)) u_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .clkEn(clkEn), .railIn(railIn), .devIn(devIn),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .power_good_out(power_good_out), .irq_out_n(irq_out_n),
        .railRunOut(railRunOut), .railSwitchOut(railSwitchOut));
    pgm_host_model u_host (.clk_sys(clk_sys), .arst_n(arst_n),
        .power_good_out(power_good_out), .irq_out_n(irq_out_n), .hostRun(hostRun));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic end_of_test();
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask
    task automatic cr(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        `CHK("register", e, regRdata & m)
    endtask
    // Bounded wait: a level that never comes counts as a mismatch
    task automatic waitPg(input logic [1:0] e);
        for (int i = 0; i < 200; i++) begin
            @(negedge clk_sys);
            if (power_good_out === e)
                return;
        end
        `CHK("pg wait", e, power_good_out)
        end_of_test();
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        `CHK("pg", 2'h0, power_good_out)
        arst_n <= 1'b1;
        wr(`PGM_REG_INT, 16'h01FF);
        cr(`PGM_REG_CTRL, 16'hFFFF, {8'h00, `PGM_CTRL_RST});
        cr(`PGM_REG_EN, 16'hFFFF, {8'h00, `PGM_EN_RST});
        for (int a = 5; a < 16; a++) begin
            rnd = lfsr(rnd);
            wr(a[3:0], {rnd, ~rnd});
            cr(a[3:0], 16'hFFFF, 16'h0000);
        end
        `CHK("pg", 2'h0, power_good_out)
        devIn.standby <= 1'b1;
        waitPg(2'h3);
        for (int i = 0; i < 3; i++) begin
            devIn <= 4'h1 | (4'h8 >> i);
            waitPg(2'h0);
            cr(`PGM_REG_INT, 16'h01FF, 16'h0040 << i);
            `CHK("irq", 1'b0, irq_out_n)
            devIn <= 4'h1;
            cyc(8);
            wr(`PGM_REG_INT, 16'h0000);
            cr(`PGM_REG_INT, 16'h01FF, 16'h0040 << i);
            wr(`PGM_REG_INT, 16'h01FF);
            cr(`PGM_REG_INT, 16'h01FF, 16'h0000);
            waitPg(2'h3);
        end
        for (int k = 0; k < 2; k++) begin
            r = 2 * k;
            wr(`PGM_REG_EN, 16'h0001 << r);
            cyc(8);
            railIn[r].ramping <= (k == 0);
            railIn[r].peakLimit <= 1'b1;
            cyc(40);
            cr(`PGM_REG_INT, 16'h01FF, k ? 16'h0020 : 16'h0000);
            railIn[r].ramping <= 1'b0;
            cyc(30);
            cr(`PGM_REG_STAT, 16'h0001 << r, 16'h0001 << r);
            cr(`PGM_REG_INT, 16'h01FF, 16'h0008 << r);
            railIn[r].peakLimit <= 1'b0;
            cyc(6);
            cr(`PGM_REG_STAT, 16'h0001 << r, 16'h0000);
            wr(`PGM_REG_INT, 16'h01FF);
            cyc(4);
            `CHK("irq", 1'b1, irq_out_n)
            `CHK("run", 1'b1, railRunOut[r])
            railIn[r].shortLevel <= 1'b1;
            railIn[r].stopLevel <= (k == 1);
            cyc(8);
            if (k == 1)
                `CHK("switch", 1'b0, railSwitchOut[2])
            cyc(40);
            `CHK("run", 1'b0, railRunOut[r])
            cr(`PGM_REG_INT, 16'h01FF, 16'h0001 << r);
            railIn[r] <= '0;
            wr(`PGM_REG_INT, 16'h01FF);
            cr(`PGM_REG_INT, 16'h01FF, 16'h0000);
            wr(`PGM_REG_EN, 16'h0000);
        end
        railIn[0].delaying <= 1'b1;
        wr(`PGM_REG_CTRL, 16'h0100);
        wr(`PGM_REG_EN, 16'h0001);
        cyc(8);
        `CHK("pg", 2'h3, power_good_out)
        railIn[0].delaying <= 1'b0;
        railIn[0].ramping <= 1'b1;
        cyc(6);
        `CHK("pg", 2'h3, power_good_out)
        cyc(40);
        `CHK("pg", 2'h2, power_good_out)
        railIn[0].ramping <= 1'b0;
        railIn[0].outDebounced <= 1'b1;
        cyc(8);
        `CHK("pg", 2'h2, power_good_out)
        wr(`PGM_REG_FAULT, 16'h0000);
        cr(`PGM_REG_FAULT, 16'h003F, 16'h0001);
        wr(`PGM_REG_FAULT, 16'h0001);
        cr(`PGM_REG_FAULT, 16'h003F, 16'h0000);
        waitPg(2'h3);
        wr(`PGM_REG_CTRL, 16'h0101);
        railIn[0].outDebounced <= 1'b0;
        waitPg(2'h2);
        railIn[0].outDebounced <= 1'b1;
        waitPg(2'h3);
        railIn[0].vChange <= 1'b1;
        waitPg(2'h2);
        railIn[0].vChange <= 1'b0;
        waitPg(2'h3);
        clkEn <= 1'b0;
        railIn[0].outDebounced <= 1'b0;
        cyc(10);
        `CHK("pg frozen", 2'h3, power_good_out)
        clkEn <= 1'b1;
        wr(`PGM_REG_CTRL, 16'h0105);
        railIn[0].outDebounced <= 1'b0;
        waitPg(2'h2);
        railIn[0].outDebounced <= 1'b1;
        cyc(10);
        `CHK("pg", 2'h2, power_good_out)
        wr(`PGM_REG_FAULT, 16'h003F);
        waitPg(2'h3);
        railIn[0].outDebounced <= 1'b0;
        wr(`PGM_REG_EN, 16'h0000);
        wr(`PGM_REG_FAULT, 16'h003F);
        waitPg(2'h3);
        cyc(4);
        `CHK("host", 1'b1, hostRun)
        end_of_test();
    end
endmodule
`default_nettype wire
